// ==== verilog/ocf_map.svh ====
// Register map, reset values, mask bit positions and inrush timing constants.
// Assumes a single 40 MHz system clock; included by bare name.
`ifndef OCF_MAP_SVH
`define OCF_MAP_SVH

// ==========================================================================
// Register addresses and reset values
`define OCF_ADDR_W 4
`define OCF_DATA_W 8
`define OCF_ADDR_OUTPUT_MODE 4'hD
`define OCF_ADDR_CURRENT_LIMIT 4'hE
`define OCF_ADDR_FAULT_MASK 4'hF
`define OCF_RST_OUTPUT_MODE 8'h00
`define OCF_RST_CURRENT_LIMIT 8'h00
`define OCF_RST_FAULT_MASK 8'hBE
`define OCF_RDATA_UNMAPPED 8'h00

// ==========================================================================
// Fault mask bit positions
`define OCF_MSK_COMM 7
`define OCF_MSK_SUPPLY 6
`define OCF_MSK_LOW_WARN 5
`define OCF_MSK_SHORT 4
`define OCF_MSK_ABOVE 3
`define OCF_MSK_OPEN_WIRE 2
`define OCF_MSK_CURR_LIM 1
`define OCF_MSK_OVERLOAD 0

// ==========================================================================
// Channel layout and inrush window timing
`define OCF_NUM_CH 4
`define OCF_FIELD_W 2
`define OCF_CLK_KHZ 40000
`define OCF_INRUSH_CODE0_MS 20
`define OCF_INRUSH_CODE1_MS 50
`define OCF_INRUSH_CODE2_MS 40
`define OCF_INRUSH_CODE3_MS 10
`define OCF_INRUSH_CODE0_CYC (`OCF_INRUSH_CODE0_MS * `OCF_CLK_KHZ)
`define OCF_INRUSH_CODE1_CYC (`OCF_INRUSH_CODE1_MS * `OCF_CLK_KHZ)
`define OCF_INRUSH_CODE2_CYC (`OCF_INRUSH_CODE2_MS * `OCF_CLK_KHZ)
`define OCF_INRUSH_CODE3_CYC (`OCF_INRUSH_CODE3_MS * `OCF_CLK_KHZ)
`define OCF_INRUSH_CNT_W 21

`endif

// ==== verilog/ocf_pkg.sv ====
// Types shared by the output configuration and fault mask block.
// Constants live in ocf_map.svh; nothing here depends on the clock.
package ocf_pkg;

  // ========================================================================
  // Output mode and current limit codes
  typedef enum logic [1:0] {
    OCF_MODE_HS = 2'h0,
    OCF_MODE_HS_INRUSH = 2'h1,
    OCF_MODE_PP_CLAMP = 2'h2,
    OCF_MODE_PP_SIMPLE = 2'h3
  } ocf_do_mode_e;

  typedef enum logic [1:0] {
    OCF_LIM_600MA = 2'h0,
    OCF_LIM_130MA = 2'h1,
    OCF_LIM_300MA = 2'h2,
    OCF_LIM_1200MA = 2'h3
  } ocf_limit_e;

  typedef enum logic [1:0] {
    OCF_TMR_IDLE = 2'b01,
    OCF_TMR_RUN = 2'b10
  } ocf_tmr_state_e;

  // ========================================================================
  // Fault sources from the analog detectors, bit 0 of each vector is channel one
  typedef struct packed {
    logic supply_err;
    logic supply_low_warn;
    logic [3:0] short_det;
    logic [3:0] above_supply;
    logic [3:0] open_wire_off;
    logic [3:0] current_limit;
    logic [3:0] overload;
  } ocf_analog_s;

  // Flags toward the interrupt register and the serial response
  typedef struct packed {
    logic comm_error_flag;
    logic supply_error_flag;
    logic global_fault_indicator;
    logic [3:0] channel_short_flag;
    logic short_indicator;
    logic [3:0] channel_current_limit_flag;
    logic overcurrent_indicator;
    logic [3:0] channel_overload_flag;
    logic overload_indicator;
  } ocf_flags_s;

  // Two-bit field of one channel out of a packed configuration byte
  function automatic logic [1:0] ocf_field(input logic [7:0] packed_byte, input int unsigned ch);
    return packed_byte[ch*2 +: 2];
  endfunction : ocf_field

endpackage : ocf_pkg

// ==== verilog/ocf_inrush_timer.sv ====
// One channel's doubled-current inrush window timer.
// Assumes drive_on, mode and limit code come from logic on clk_sys.
`timescale 1ns/10ps
`include "ocf_map.svh"
module ocf_inrush_timer #(
  parameter int CNT_W = `OCF_INRUSH_CNT_W,
  parameter logic [CNT_W-1:0] CYC0 = CNT_W'(`OCF_INRUSH_CODE0_CYC),
  parameter logic [CNT_W-1:0] CYC1 = CNT_W'(`OCF_INRUSH_CODE1_CYC),
  parameter logic [CNT_W-1:0] CYC2 = CNT_W'(`OCF_INRUSH_CODE2_CYC),
  parameter logic [CNT_W-1:0] CYC3 = CNT_W'(`OCF_INRUSH_CODE3_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire ocf_pkg::ocf_do_mode_e mode,
  input wire logic [1:0] limit_code,
  input wire logic drive_on,
  output logic inrush_active
);

  ocf_pkg::ocf_tmr_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] win_len, next_win_len;
  logic drive_prev, next_drive_prev;
  logic start;

  // ========================================================================
  // Window start on a turn-on edge in the doubled-inrush mode
  assign start = drive_on && !drive_prev && (mode == ocf_pkg::OCF_MODE_HS_INRUSH); // see RULE3

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_win_len = win_len;
    next_drive_prev = drive_on;
    case (state)
      ocf_pkg::OCF_TMR_IDLE: begin
        if (start) begin
          next_state = ocf_pkg::OCF_TMR_RUN;
          next_cnt = '0;
          case (limit_code) // see RULE5
            2'h0: next_win_len = CYC0;
            2'h1: next_win_len = CYC1;
            2'h2: next_win_len = CYC2;
            default: next_win_len = CYC3;
          endcase
        end
      end
      ocf_pkg::OCF_TMR_RUN: begin
        // Turning off or leaving the mode ends the window early
        if (!drive_on || mode != ocf_pkg::OCF_MODE_HS_INRUSH || cnt == win_len - 1'b1) begin // see RULE5
          next_state = ocf_pkg::OCF_TMR_IDLE;
        end else begin
          next_cnt = CNT_W'(cnt + 1'b1);
        end
      end
      default: next_state = ocf_pkg::OCF_TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ocf_pkg::OCF_TMR_IDLE;
      cnt <= '0;
      win_len <= '0;
      drive_prev <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      win_len <= next_win_len;
      drive_prev <= next_drive_prev;
    end
  end

  assign inrush_active = (state == ocf_pkg::OCF_TMR_RUN);

  // ========================================================================
  // Checks
  chk_inrush_start: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE3
    ce && start |=> inrush_active) else $error("inrush window did not open");
  chk_inrush_bound: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE5
    inrush_active |-> cnt < win_len) else $error("inrush window ran past its length");
  cov_inrush_full: cover property (@(posedge clk_sys) disable iff (!reset_n)
    inrush_active && ce && cnt == win_len - 1'b1 && drive_on);

endmodule : ocf_inrush_timer

// ==== verilog/ocf_fault_combine.sv ====
// Fault pin combining and always-on flag generation.
// Assumes all inputs are already synchronised to clk_sys.
`timescale 1ns/10ps
`include "ocf_map.svh"
module ocf_fault_combine (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] mask,
  input wire logic comm_err,
  input wire ocf_pkg::ocf_analog_s src,
  input wire logic [3:0] short_detect_en,
  output logic fault_n,
  output ocf_pkg::ocf_flags_s flags
);

  logic next_fault_n;
  ocf_pkg::ocf_flags_s next_flags;
  logic [3:0] short_seen;

  // ========================================================================
  // Flags ignore the mask entirely; only the pin is gated
  assign short_seen = src.short_det & short_detect_en; // see RULE14

  always_comb begin
    next_flags.comm_error_flag = comm_err; // see RULE9
    next_flags.supply_error_flag = src.supply_err | src.supply_low_warn; // see RULE11 see RULE12
    next_flags.channel_short_flag = short_seen; // see RULE14
    next_flags.short_indicator = |short_seen;
    next_flags.channel_current_limit_flag = src.current_limit; // see RULE15
    next_flags.overcurrent_indicator = |src.current_limit;
    next_flags.channel_overload_flag = src.overload; // see RULE16
    next_flags.overload_indicator = |src.overload;
    next_flags.global_fault_indicator = comm_err | src.supply_err | src.supply_low_warn | (|short_seen)
      | (|src.current_limit) | (|src.overload); // see RULE9 see RULE11
    // Any unmasked source pulls the pin low
    next_fault_n = !((comm_err && !mask[`OCF_MSK_COMM]) // see RULE8
      || (src.supply_err && !mask[`OCF_MSK_SUPPLY]) // see RULE10
      || (src.supply_low_warn && !mask[`OCF_MSK_LOW_WARN]) // see RULE12
      || ((|short_seen) && !mask[`OCF_MSK_SHORT]) // see RULE13
      || ((|src.above_supply) && !mask[`OCF_MSK_ABOVE])
      || ((|src.open_wire_off) && !mask[`OCF_MSK_OPEN_WIRE])
      || ((|src.current_limit) && !mask[`OCF_MSK_CURR_LIM]) // see RULE15
      || ((|src.overload) && !mask[`OCF_MSK_OVERLOAD])); // see RULE16 see RULE17
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fault_n <= 1'b1;
      flags <= '0;
    end else if (ce) begin
      fault_n <= next_fault_n;
      flags <= next_flags;
    end
  end

endmodule : ocf_fault_combine

// ==== verilog/ocf_regs.sv ====
// Output mode, current limit and fault mask registers of a four-channel output device.
// Assumes the serial front end delivers decoded register reads and writes on clk_sys,
// and that the analog fault detectors are asynchronous to clk_sys.
//
// Functional notes
// RULE1 - Two-bit mode per channel: high-side, high-side doubled inrush, clamp push-pull, push-pull.
// RULE2 - Mode byte: channel four bits 7:6 down to channel one bits 1:0.
// RULE3 - Mode 01 doubles current limit for an inrush window set by limit code.
// RULE4 - Two-bit limit code 600, 130, 300, 1200 mA, passed to the limiter.
// RULE5 - Inrush window by limit code: 20, 50, 40, 10 ms, counted in cycles.
// RULE6 - Limit byte: channel four bits 7:6 down to channel one bits 1:0.
// RULE7 - Mask bit zero lets a source assert the fault pin; one blocks it.
// RULE8 - Mask bit 7 gates watchdog and serial/CRC errors onto the pin.
// RULE9 - Communication errors always set their flag and the global fault indicator.
// RULE10 - Mask bit 6 gates supply errors onto the fault pin.
// RULE11 - Supply errors always set their flag and the global fault indicator.
// RULE12 - Mask bit 5 gates supply low and warning only; supply flag unaffected.
// RULE13 - Mask bit 4 gates short-to-supply error onto the fault pin.
// RULE14 - Enabled short detection sets the channel short flag and short indicator.
// RULE15 - Mask bit 1 gates current limit; limit flags and indicator always set.
// RULE16 - Mask bit 0 gates thermal overload; overload flags and indicator always set.
// RULE17 - Fault pin low while any unmasked source is active, sources ORed.
// RULE18 - Written mode and limit codes reach the drivers right after the write.
`timescale 1ns/10ps
`include "ocf_map.svh"
module ocf_regs #(
  parameter int NUM_CH = `OCF_NUM_CH,
  parameter int CNT_W = `OCF_INRUSH_CNT_W,
  parameter int unsigned INRUSH_CYC_CODE0 = `OCF_INRUSH_CODE0_CYC,
  parameter int unsigned INRUSH_CYC_CODE1 = `OCF_INRUSH_CODE1_CYC,
  parameter int unsigned INRUSH_CYC_CODE2 = `OCF_INRUSH_CODE2_CYC,
  parameter int unsigned INRUSH_CYC_CODE3 = `OCF_INRUSH_CODE3_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`OCF_ADDR_W-1:0] reg_addr,
  input wire logic [`OCF_DATA_W-1:0] reg_wdata,
  output logic [`OCF_DATA_W-1:0] reg_rdata,
  input wire logic watchdog_err,
  input wire logic link_err,
  input wire ocf_pkg::ocf_analog_s analog_raw,
  input wire logic [3:0] short_detect_en,
  input wire logic [3:0] drive_on,
  output ocf_pkg::ocf_do_mode_e ch1_output_mode,
  output ocf_pkg::ocf_do_mode_e ch2_output_mode,
  output ocf_pkg::ocf_do_mode_e ch3_output_mode,
  output ocf_pkg::ocf_do_mode_e ch4_output_mode,
  output logic [1:0] ch1_limit_code,
  output logic [1:0] ch2_limit_code,
  output logic [1:0] ch3_limit_code,
  output logic [1:0] ch4_limit_code,
  output logic [3:0] inrush_active,
  output logic fault_n,
  output ocf_pkg::ocf_flags_s flags
);

  // ==========================================================================
  // Register storage
  logic [7:0] output_mode_select, next_output_mode_select;
  logic [7:0] current_limit_select, next_current_limit_select;
  logic [7:0] fault_pin_mask, next_fault_pin_mask;
  logic [7:0] next_reg_rdata;
  logic wr_mode, wr_limit, wr_mask;

  assign wr_mode = reg_wr && (reg_addr == `OCF_ADDR_OUTPUT_MODE);
  assign wr_limit = reg_wr && (reg_addr == `OCF_ADDR_CURRENT_LIMIT);
  assign wr_mask = reg_wr && (reg_addr == `OCF_ADDR_FAULT_MASK);

  always_comb begin
    next_output_mode_select = wr_mode ? reg_wdata : output_mode_select; // see RULE2 see RULE18
    next_current_limit_select = wr_limit ? reg_wdata : current_limit_select; // see RULE6 see RULE18
    next_fault_pin_mask = wr_mask ? reg_wdata : fault_pin_mask; // see RULE7
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `OCF_ADDR_OUTPUT_MODE: next_reg_rdata = output_mode_select;
        `OCF_ADDR_CURRENT_LIMIT: next_reg_rdata = current_limit_select;
        `OCF_ADDR_FAULT_MASK: next_reg_rdata = fault_pin_mask;
        default: next_reg_rdata = `OCF_RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      output_mode_select <= `OCF_RST_OUTPUT_MODE;
      current_limit_select <= `OCF_RST_CURRENT_LIMIT;
      fault_pin_mask <= `OCF_RST_FAULT_MASK;
      reg_rdata <= `OCF_RDATA_UNMAPPED;
    end else if (ce) begin
      output_mode_select <= next_output_mode_select;
      current_limit_select <= next_current_limit_select;
      fault_pin_mask <= next_fault_pin_mask;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ==========================================================================
  // Per-channel fields straight from the flops, so no extra trigger is needed
  assign ch1_output_mode = ocf_pkg::ocf_do_mode_e'(ocf_pkg::ocf_field(output_mode_select, 0)); // see RULE1 see RULE2
  assign ch2_output_mode = ocf_pkg::ocf_do_mode_e'(ocf_pkg::ocf_field(output_mode_select, 1)); // see RULE1
  assign ch3_output_mode = ocf_pkg::ocf_do_mode_e'(ocf_pkg::ocf_field(output_mode_select, 2)); // see RULE1
  assign ch4_output_mode = ocf_pkg::ocf_do_mode_e'(ocf_pkg::ocf_field(output_mode_select, 3)); // see RULE1
  assign ch1_limit_code = ocf_pkg::ocf_field(current_limit_select, 0); // see RULE4 see RULE6
  assign ch2_limit_code = ocf_pkg::ocf_field(current_limit_select, 1); // see RULE4
  assign ch3_limit_code = ocf_pkg::ocf_field(current_limit_select, 2); // see RULE4
  assign ch4_limit_code = ocf_pkg::ocf_field(current_limit_select, 3); // see RULE4

  // ==========================================================================
  // Inrush window timers, one per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_inrush
      ocf_inrush_timer #(
        .CNT_W(CNT_W),
        .CYC0(CNT_W'(INRUSH_CYC_CODE0)),
        .CYC1(CNT_W'(INRUSH_CYC_CODE1)),
        .CYC2(CNT_W'(INRUSH_CYC_CODE2)),
        .CYC3(CNT_W'(INRUSH_CYC_CODE3))
      ) u_timer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ce(ce),
        .mode(ocf_pkg::ocf_do_mode_e'(ocf_pkg::ocf_field(output_mode_select, gi))), // see RULE3
        .limit_code(ocf_pkg::ocf_field(current_limit_select, gi)), // see RULE5
        .drive_on(drive_on[gi]),
        .inrush_active(inrush_active[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Detector inputs cross in through two flops; the first is read by nothing else
  ocf_pkg::ocf_analog_s analog_meta, analog_sync;
  ocf_pkg::ocf_analog_s next_analog_meta, next_analog_sync;
  logic comm_err;

  always_comb begin
    next_analog_meta = analog_raw;
    next_analog_sync = analog_meta;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      analog_meta <= '0;
      analog_sync <= '0;
    end else if (ce) begin
      analog_meta <= next_analog_meta;
      analog_sync <= next_analog_sync;
    end
  end

  // Watchdog and link errors are produced on clk_sys and need no synchroniser
  assign comm_err = watchdog_err | link_err; // see RULE8

  ocf_fault_combine u_combine (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ce(ce),
    .mask(fault_pin_mask),
    .comm_err(comm_err),
    .src(analog_sync),
    .short_detect_en(short_detect_en),
    .fault_n(fault_n),
    .flags(flags)
  );

  // ==========================================================================
  // Checks
  chk_mode_write_lands: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE18
    ce && wr_mode |=> {ch4_output_mode, ch3_output_mode, ch2_output_mode, ch1_output_mode} == $past(reg_wdata))
    else $error("mode write did not reach the channel outputs");

  chk_limit_write_lands: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE6
    ce && wr_limit |=> {ch4_limit_code, ch3_limit_code, ch2_limit_code, ch1_limit_code} == $past(reg_wdata))
    else $error("limit write did not reach the channel outputs");

  chk_comm_pin_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE8
    ce && comm_err && !fault_pin_mask[`OCF_MSK_COMM] |=> !fault_n)
    else $error("unmasked communication error did not pull fault pin low");

  chk_supply_pin_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE10
    ce && analog_sync.supply_err && !fault_pin_mask[`OCF_MSK_SUPPLY] |=> !fault_n)
    else $error("unmasked supply error did not pull fault pin low");

  chk_all_masked_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE7
    ce && (&fault_pin_mask) |=> fault_n)
    else $error("fault pin asserted while every source is masked");

  chk_pin_or_sources: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE17
    ce && !comm_err && (analog_sync == '0) |=> fault_n)
    else $error("fault pin low with no active source");

  chk_comm_flag_always: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE9
    ce && comm_err |=> flags.comm_error_flag && flags.global_fault_indicator)
    else $error("communication error flag missing");

  chk_supply_flag_always: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE11
    ce && (analog_sync.supply_err || analog_sync.supply_low_warn) |=> flags.supply_error_flag)
    else $error("supply error flag missing");

  chk_low_warn_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE12
    ce && analog_sync.supply_low_warn && !fault_pin_mask[`OCF_MSK_LOW_WARN] |=> !fault_n)
    else $error("unmasked supply low warning did not pull fault pin low");

  chk_short_flag_set: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE14
    ce && |(analog_sync.short_det & short_detect_en) |=> flags.short_indicator)
    else $error("enabled short not reported");

  chk_short_pin_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE13
    ce && |(analog_sync.short_det & short_detect_en) && !fault_pin_mask[`OCF_MSK_SHORT] |=> !fault_n)
    else $error("unmasked short did not pull fault pin low");

  chk_curr_lim_flag: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE15
    ce && (|analog_sync.current_limit) |=> flags.overcurrent_indicator
      && flags.channel_current_limit_flag == $past(analog_sync.current_limit))
    else $error("current limit flags wrong");

  chk_overload_flag: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE16
    ce && (|analog_sync.overload) |=> flags.overload_indicator
      && flags.channel_overload_flag == $past(analog_sync.overload))
    else $error("overload flags wrong");

  chk_mask_write_lands: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE7
    ce && wr_mask
    |=> fault_pin_mask == $past(reg_wdata))
    else $error("mask write did not land");

  // A read in the same cycle as a write returns the old value
  chk_mode_read_back: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE2
    ce && reg_rd && reg_addr == `OCF_ADDR_OUTPUT_MODE
    |=> reg_rdata == $past(output_mode_select))
    else $error("mode readback wrong");

  chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && reg_rd && reg_addr < `OCF_ADDR_OUTPUT_MODE
    |=> reg_rdata == `OCF_RDATA_UNMAPPED)
    else $error("unmapped read not zero");

  chk_ce_freeze: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !ce
    |=> $stable(output_mode_select) && $stable(fault_pin_mask) && $stable(fault_n))
    else $error("state moved while clock enable low");

  chk_above_pin_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE17
    ce && (|analog_sync.above_supply) && !fault_pin_mask[`OCF_MSK_ABOVE]
    |=> !fault_n)
    else $error("unmasked above-supply error did not pull fault pin low");

  chk_curr_lim_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE15
    ce && (|analog_sync.current_limit) && !fault_pin_mask[`OCF_MSK_CURR_LIM]
    |=> !fault_n)
    else $error("unmasked current limit did not pull fault pin low");

  chk_overload_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) // see RULE16
    ce && (|analog_sync.overload) && !fault_pin_mask[`OCF_MSK_OVERLOAD]
    |=> !fault_n)
    else $error("unmasked overload did not pull fault pin low");

  cov_mode_write: cover property (@(posedge clk_sys) disable iff (!reset_n) ce && wr_mode);
  cov_masked_comm: cover property (@(posedge clk_sys) disable iff (!reset_n)
    ce && comm_err && fault_pin_mask[`OCF_MSK_COMM] ##1 fault_n);
  cov_unmasked_overload: cover property (@(posedge clk_sys) disable iff (!reset_n)
    ce && (|analog_sync.overload) && !fault_pin_mask[`OCF_MSK_OVERLOAD] ##1 !fault_n);
  cov_inrush_any: cover property (@(posedge clk_sys) disable iff (!reset_n) |inrush_active);

endmodule : ocf_regs

// ==== tb/ocf_host_model.sv ====
// Host side of the decoded register port: single-byte writes and reads.
// Assumes strobes are taken on rising clk_sys with ce held high.
`timescale 1ns/10ps
module ocf_host_model (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
  end
  // ========================================================================
  // Bus cycles; address and data are inverted on release so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : ocf_host_model

// ==== tb/ocf_regs_tb.sv ====
// Self-checking bench: register table, reset defaults, fault masking, inrush windows.
// Assumes ocf_map.svh on the include path; inrush counts shortened to 8, 20, 16, 4.
`timescale 1ns/10ps
`include "ocf_map.svh"
module ocf_regs_tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, ce = 1'b1, watchdog_err = 1'b0, link_err = 1'b0;
  logic reg_wr, reg_rd, fault_n;
  logic [3:0] reg_addr, inrush_active, short_detect_en = 4'hF, drive_on = 4'h0;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [1:0] ch1_limit_code, ch2_limit_code, ch3_limit_code, ch4_limit_code;
  ocf_pkg::ocf_do_mode_e ch1_output_mode, ch2_output_mode, ch3_output_mode, ch4_output_mode;
  ocf_pkg::ocf_analog_s analog_raw = '0;
  ocf_pkg::ocf_flags_s flags;
  int err_count = 0, comparisons = 0, n;
  localparam int INR[4] = '{8, 20, 16, 4};
  // Rows: address, write data, expected readback
  logic [19:0] rows[5] = '{20'hDE4E4, 20'hE1B1B, 20'hF0000, 20'h35500, 20'hD1B1B};
  always #12.5 clk_sys = ~clk_sys;
  ocf_host_model i_host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  ocf_regs #(.INRUSH_CYC_CODE0(8), .INRUSH_CYC_CODE1(20), .INRUSH_CYC_CODE2(16), .INRUSH_CYC_CODE3(4)) i_dut (
    .clk_sys, .reset_n, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .watchdog_err,
    .link_err, .analog_raw, .short_detect_en, .drive_on, .ch1_output_mode, .ch2_output_mode, .ch3_output_mode,
    .ch4_output_mode, .ch1_limit_code, .ch2_limit_code, .ch3_limit_code, .ch4_limit_code, .inrush_active,
    .fault_n, .flags);
  // ========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : wait_cyc
  // One fault source on channel three; 8 means link error under mask bit 7
  task automatic src(input int b, input logic on);
    ocf_pkg::ocf_analog_s a;
    a = '0;
    case (b)
      6: a.supply_err = on;
      5: a.supply_low_warn = on;
      4: a.short_det[2] = on;
      3: a.above_supply[2] = on;
      2: a.open_wire_off[2] = on;
      1: a.current_limit[2] = on;
      0: a.overload[2] = on;
      default: ;
    endcase
    analog_raw = a;
    watchdog_err = on && b == 7;
    link_err = on && b == 8;
  endtask : src
  function automatic logic flg(input int b);
    case (b)
      7, 8: return flags.comm_error_flag;
      6, 5: return flags.supply_error_flag;
      4: return flags.short_indicator & flags.channel_short_flag[2];
      1: return flags.overcurrent_indicator & flags.channel_current_limit_flag[2];
      0: return flags.overload_indicator & flags.channel_overload_flag[2];
      default: return flags == '0;
    endcase
  endfunction : flg
  // ========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    close_out();
  end
  // ========================================================================
  // Main sequence
  initial begin
    wait_cyc(10);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      i_host.wr(rows[i][19:16], rows[i][15:8]);
      if (rows[i][19:16] == 4'hD)
        chk("modes", rows[i][7:0], {ch4_output_mode, ch3_output_mode, ch2_output_mode, ch1_output_mode});
      if (rows[i][19:16] == 4'hE)
        chk("limits", rows[i][7:0], {ch4_limit_code, ch3_limit_code, ch2_limit_code, ch1_limit_code});
      i_host.rd(rows[i][19:16], d);
      chk("readback", rows[i][7:0], d);
    end
    // Second reset in mid-run brings back the defaults
    reset_n = 1'b0;
    wait_cyc(2);
    reset_n = 1'b1;
    i_host.rd(4'hD, d);
    chk("mode reset", 8'h00, d);
    i_host.rd(4'hE, d);
    chk("limit reset", 8'h00, d);
    i_host.rd(4'hF, d);
    chk("mask reset", 8'hBE, d);
    chk("fault_n reset", 8'h01, fault_n);
    for (int b = 0; b < 9; b++) begin
      i_host.wr(4'hF, 8'hFF);
      src(b, 1'b1);
      wait_cyc(4);
      chk("fault_n masked", 8'h01, fault_n);
      chk("source flag", 8'h01, flg(b));
      chk("global", (b == 2 || b == 3) ? 8'h00 : 8'h01, flags.global_fault_indicator);
      i_host.wr(4'hF, ~(8'h01 << ((b > 7) ? 7 : b)));
      wait_cyc(2);
      chk("fault_n unmasked", 8'h00, fault_n);
      src(b, 1'b0);
      wait_cyc(4);
      chk("fault_n cleared", 8'h01, fault_n);
    end
    short_detect_en = 4'h0;
    src(4, 1'b1);
    wait_cyc(4);
    chk("short disabled", 8'h00, flags.short_indicator);
    src(4, 1'b0);
    short_detect_en = 4'hF;
    // Clock enable low freezes the registers, so this write must not land
    ce = 1'b0;
    i_host.wr(4'hD, 8'hFF);
    chk("ce frozen", 8'h00, {ch4_output_mode, ch3_output_mode, ch2_output_mode, ch1_output_mode});
    ce = 1'b1;
    // Channel one in doubled inrush mode, channel two plain high-side must never open a window
    i_host.wr(4'hD, 8'h01);
    for (int c = 0; c < 4; c++) begin
      i_host.wr(4'hE, 8'(c));
      drive_on = 4'h3;
      n = 0;
      repeat (40) begin
        wait_cyc(1);
        n += inrush_active[0] + 100 * inrush_active[1];
      end
      chk("inrush cycles", 8'(INR[c]), 8'(n));
      drive_on = 4'h0;
    end
    close_out();
  end
endmodule : ocf_regs_tb
